// [emr_regs.svh]
// Purpose: offsets, field positions and reset values of the error router
// Assumes: printed offsets are register indexes; byte address is 4 * index
// Notes: definitions only
`ifndef EMR_REGS_SVH
`define EMR_REGS_SVH

// ==========================================================================
// register indexes
`define EMR_IDX_FLAGS 8'hc8
`define EMR_IDX_SERR 8'hca
`define EMR_IDX_SMI 8'hcc
`define EMR_IDX_SCI 8'hce
`define EMR_IDX_SCRATCH 8'hde

// ==========================================================================
// reset values and writable masks
`define EMR_RST_ENABLE 16'h0000
`define EMR_RST_SCRATCH 16'h0000
`define EMR_RST_FLAGS 16'h0000
`define EMR_MASK_SERR 16'h03fe
`define EMR_MASK_ECC 16'h0180
`define EMR_MASK_SCRATCH 16'hffff

// ==========================================================================
// field positions, shared by enable and flag registers
`define EMR_BIT_LOCK_MISS 9
`define EMR_BIT_MULTIBIT 8
`define EMR_BIT_SINGLEBIT 7
`define EMR_BIT_TARGET_ABORT 6
`define EMR_BIT_UNKNOWN_SC 5
`define EMR_BIT_OUTSIDE 4
`define EMR_BIT_INVALID 3
`define EMR_BIT_BAD_ENTRY 2
`define EMR_BIT_UNSUP_CMD 1

`endif

// [emr_pkg.sv]
// Purpose: types of the error message router
// Assumes: nothing
// Notes: numbers live in emr_regs.svh
package emr_pkg;
	typedef logic [15:0] emr_word_t;
	typedef enum {
		EMR_SEL_NONE,
		EMR_SEL_FLAGS,
		EMR_SEL_SERR,
		EMR_SEL_SMI,
		EMR_SEL_SCI,
		EMR_SEL_SCRATCH
	} emr_sel_e;
endpackage : emr_pkg

// [emr_msg_if.sv]
// Purpose: carries flags and enables to the message generator and back
// Assumes: single clock domain
// Notes: ctl is the register side, gen the message side
interface emr_msg_if;
	import emr_pkg::*;
	emr_word_t flags;
	emr_word_t serr_en;
	emr_word_t smi_en;
	emr_word_t sci_en;
	logic global_en;
	logic serr_msg;
	logic smi_msg;
	logic sci_msg;
	emr_word_t src;
	modport ctl (output flags, serr_en, smi_en, sci_en, global_en,
		input serr_msg, smi_msg, sci_msg, src);
	modport gen (input flags, serr_en, smi_en, sci_en, global_en,
		output serr_msg, smi_msg, sci_msg, src);
endinterface : emr_msg_if

// [emr_msg_gen.sv]
// Purpose: turns rising error flags into hub link message pulses
// Assumes: flags come from registers on pclk
// Notes: one pulse per kind per cycle, src marks every source it covers
module emr_msg_gen import emr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	emr_msg_if.gen mi
);

	// ======================================================================
	// edge detection and gating
	emr_word_t prev_r;
	emr_word_t rise;
	emr_word_t serr_hit;
	emr_word_t smi_hit;
	emr_word_t sci_hit;
	logic serr_msg_r;
	logic smi_msg_r;
	logic sci_msg_r;
	emr_word_t src_r;

	// a flag that stays set never fires again; only a fresh rise counts
	assign rise = mi.flags & ~prev_r;

	for (genvar i = 0; i < 16; i++) begin : g_src
		assign serr_hit[i] = rise[i] & mi.serr_en[i] & mi.global_en;
		assign smi_hit[i] = rise[i] & mi.smi_en[i];
		assign sci_hit[i] = rise[i] & mi.sci_en[i];
	end

	// ======================================================================
	// message registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 16'h0000;
			serr_msg_r <= 1'b0;
			smi_msg_r <= 1'b0;
			sci_msg_r <= 1'b0;
			src_r <= 16'h0000;
		end else begin
			prev_r <= mi.flags;
			serr_msg_r <= |serr_hit;
			smi_msg_r <= |smi_hit;
			sci_msg_r <= |sci_hit;
			src_r <= serr_hit | smi_hit | sci_hit;
		end
	end

	assign mi.serr_msg = serr_msg_r;
	assign mi.smi_msg = smi_msg_r;
	assign mi.sci_msg = sci_msg_r;
	assign mi.src = src_r;

endmodule : emr_msg_gen

// [emr_error_message_router.sv]
// Purpose: error enables, error flags and scratch storage behind APB
// Assumes: error events and the global enable are on pclk
// Notes: zero-wait APB slave, answer in the cycle after setup
//
// Operation
// - a flag that rises with its enable bit on sends one system-error message
// - no system-error message unless the global command enable is set
// - bit 9: locked cycle missing system memory sends system-error
// - bit 8: multiple-bit memory error sends system-error
// - bit 7: single-bit correctable memory error sends system-error
// - bit 6: own hub link cycle ending in target abort sends system-error
// - bit 5: unknown special cycle received sends system-error, else none
// - bit 4: graphics access outside the aperture sends system-error
// - bit 3: outside aperture into low window or above memory top
// - bit 2: invalid translation entry inside aperture sends system-error
// - bit 1: unsupported graphics command sends system-error, else none
// - management bit 8: multiple-bit error sends management message
// - management bit 7: single-bit error sends management message
// - control bit 8: multiple-bit error sends control-interrupt message
// - control bit 7: single-bit error sends control-interrupt message
// - sixteen-bit scratch storage, read back whole, affects nothing
// - enables and scratch reset to zero; reserved bits read zero
// - flags stay set until software writes one; zero leaves them
`include "emr_regs.svh"

module emr_error_message_router import emr_pkg::*; #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] err_event,
	input wire logic serr_global_en,
	output logic hub_serr_msg,
	output logic hub_smi_msg,
	output logic hub_sci_msg,
	output logic [15:0] hub_msg_src
);

	// every check below runs on pclk and sleeps through reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ======================================================================
	// state
	emr_word_t flag_r;
	emr_word_t flag_nxt;
	emr_word_t serr_en_r;
	emr_word_t serr_en_nxt;
	emr_word_t smi_en_r;
	emr_word_t smi_en_nxt;
	emr_word_t sci_en_r;
	emr_word_t sci_en_nxt;
	emr_word_t scratch_r;
	emr_word_t scratch_nxt;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// ======================================================================
	// address decode
	logic [7:0] idx;
	logic hi_zero;
	emr_sel_e sel;
	logic setup;
	logic commit;
	logic wr;
	emr_word_t be16;
	emr_word_t wdata;
	emr_word_t w1c;
	emr_word_t rdata;

	assign idx = paddr[9:2];
	assign hi_zero = (paddr[ADDR_W-1:10] == '0);
	assign sel = !hi_zero ? EMR_SEL_NONE :
		(idx == `EMR_IDX_FLAGS) ? EMR_SEL_FLAGS :
		(idx == `EMR_IDX_SERR) ? EMR_SEL_SERR :
		(idx == `EMR_IDX_SMI) ? EMR_SEL_SMI :
		(idx == `EMR_IDX_SCI) ? EMR_SEL_SCI :
		(idx == `EMR_IDX_SCRATCH) ? EMR_SEL_SCRATCH :
		EMR_SEL_NONE;

	// setup samples the read, the access edge with pready commits a write
	assign setup = psel & ~penable;
	assign commit = psel & penable & pready_r;
	assign wr = commit & pwrite;
	assign be16 = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wdata = pwdata[15:0] & be16;

	// ======================================================================
	// next values of the software registers
	// only documented bits take a write, the rest stay zero
	assign serr_en_nxt = (wr && sel == EMR_SEL_SERR) ?
		((serr_en_r & ~be16) | (wdata & `EMR_MASK_SERR)) :
		serr_en_r;
	assign smi_en_nxt = (wr && sel == EMR_SEL_SMI) ?
		((smi_en_r & ~be16) | (wdata & `EMR_MASK_ECC)) :
		smi_en_r;
	assign sci_en_nxt = (wr && sel == EMR_SEL_SCI) ?
		((sci_en_r & ~be16) | (wdata & `EMR_MASK_ECC)) :
		sci_en_r;
	assign scratch_nxt = (wr && sel == EMR_SEL_SCRATCH) ?
		((scratch_r & ~be16) | (wdata & `EMR_MASK_SCRATCH)) :
		scratch_r;

	// write one clears; a new event in the same cycle wins over the clear
	assign w1c = (wr && sel == EMR_SEL_FLAGS) ? wdata : 16'h0000;
	assign flag_nxt = (flag_r & ~w1c) |
		(err_event & `EMR_MASK_SERR);

	// ======================================================================
	// read mux and error answer
	assign rdata = (sel == EMR_SEL_FLAGS) ? flag_r :
		(sel == EMR_SEL_SERR) ? serr_en_r :
		(sel == EMR_SEL_SMI) ? smi_en_r :
		(sel == EMR_SEL_SCI) ? sci_en_r :
		(sel == EMR_SEL_SCRATCH) ? scratch_r :
		16'h0000;

	// ======================================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serr_en_r <= `EMR_RST_ENABLE;
			smi_en_r <= `EMR_RST_ENABLE;
			sci_en_r <= `EMR_RST_ENABLE;
			scratch_r <= `EMR_RST_SCRATCH;
			flag_r <= `EMR_RST_FLAGS;
		end else begin
			serr_en_r <= serr_en_nxt;
			smi_en_r <= smi_en_nxt;
			sci_en_r <= sci_en_nxt;
			scratch_r <= scratch_nxt;
			flag_r <= flag_nxt;
		end
	end

	// the answer is prepared during setup so that every output is a flop
	// a setup held over two edges would be answered twice; apb forbids it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup & (sel == EMR_SEL_NONE);
			prdata_r <= setup ? {16'h0000, rdata} : 32'h0000_0000;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// ======================================================================
	// message generation
	emr_msg_if mi ();

	assign mi.flags = flag_r;
	assign mi.serr_en = serr_en_r;
	assign mi.smi_en = smi_en_r;
	assign mi.sci_en = sci_en_r;
	assign mi.global_en = serr_global_en;

	// conflicting enables are not policed; software keeps them apart
	emr_msg_gen u_gen (
		.pclk(pclk),
		.presetn(presetn),
		.mi(mi)
	);

	assign hub_serr_msg = mi.serr_msg;
	assign hub_smi_msg = mi.smi_msg;
	assign hub_sci_msg = mi.sci_msg;
	assign hub_msg_src = mi.src;

	// ======================================================================
	// checks
	for (genvar b = 1; b < 10; b++) begin : g_chk
		a_serr_source: assert property (
			$rose(flag_r[b]) && serr_en_r[b] && serr_global_en
			|=> hub_serr_msg && hub_msg_src[b])
			else $error("enabled flag rise sent no system-error message");
	end

	a_serr_gate: assert property (
		hub_serr_msg |-> $past(serr_global_en))
		else $error("system-error message without global enable");

	a_disabled_quiet: assert property (
		hub_msg_src[`EMR_BIT_UNKNOWN_SC] |->
		$past(serr_en_r[`EMR_BIT_UNKNOWN_SC]))
		else $error("message for a disabled special-cycle source");

	a_smi_multibit: assert property (
		$rose(flag_r[`EMR_BIT_MULTIBIT]) && smi_en_r[`EMR_BIT_MULTIBIT]
		|=> hub_smi_msg && hub_msg_src[`EMR_BIT_MULTIBIT])
		else $error("multibit error sent no management message");

	a_smi_single: assert property (
		$rose(flag_r[`EMR_BIT_SINGLEBIT]) && smi_en_r[`EMR_BIT_SINGLEBIT]
		|=> hub_smi_msg)
		else $error("singlebit error sent no management message");

	a_sci_multibit: assert property (
		$rose(flag_r[`EMR_BIT_MULTIBIT]) && sci_en_r[`EMR_BIT_MULTIBIT]
		|=> hub_sci_msg && hub_msg_src[`EMR_BIT_MULTIBIT])
		else $error("multibit error sent no control message");

	a_sci_single: assert property (
		$rose(flag_r[`EMR_BIT_SINGLEBIT]) && sci_en_r[`EMR_BIT_SINGLEBIT]
		|=> hub_sci_msg)
		else $error("singlebit error sent no control message");

	a_smi_quiet: assert property (
		hub_smi_msg |-> $past(smi_en_r) != 16'h0000)
		else $error("management message with no enable set");

	a_scratch_keep: assert property (
		!(wr && sel == EMR_SEL_SCRATCH) |=> $stable(scratch_r))
		else $error("scratch changed without a write");

	a_scratch_back: assert property (
		wr && sel == EMR_SEL_SCRATCH && pstrb[1:0] == 2'h3
		|=> scratch_r == $past(wdata))
		else $error("scratch did not store the written word");

	a_flag_sticky: assert property (
		1'b1 |=> (flag_r & $past(flag_r) & ~$past(w1c)) ==
		($past(flag_r) & ~$past(w1c)))
		else $error("flag fell without a one written to it");

	a_reserved_zero: assert property (
		(serr_en_r & ~`EMR_MASK_SERR) == 16'h0000 &&
		((smi_en_r | sci_en_r) & ~`EMR_MASK_ECC) == 16'h0000)
		else $error("reserved enable bit is set");

	a_no_repeat: assert property (
		hub_msg_src != 16'h0000 |=>
		(hub_msg_src & $past(hub_msg_src)) == 16'h0000)
		else $error("same source reported on two cycles running");

	a_apb_answer: assert property (
		setup |=> pready ##1 !pready)
		else $error("answer not given one cycle after setup");

	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("ready stood longer than one cycle");

	a_error_answer: assert property (
		setup && sel == EMR_SEL_NONE |=> pready && pslverr)
		else $error("unmapped access answered without error");

	a_quiet_bus: assert property (
		!pready |-> prdata == 32'h0000_0000 && !pslverr)
		else $error("read data or error outside the answer cycle");

	a_upper_zero: assert property (
		prdata[31:16] == 16'h0000)
		else $error("upper half of read data is not zero");

	// enables change only through a committed write, masked to their bits
	a_enable_keep: assert property (
		!wr |=> $stable(serr_en_r) && $stable(smi_en_r) &&
		$stable(sci_en_r))
		else $error("enable register changed without a write");

	a_enable_store: assert property (
		wr && sel == EMR_SEL_SERR && pstrb[1:0] == 2'h3 |=>
		serr_en_r == ($past(wdata) & `EMR_MASK_SERR))
		else $error("system-error enable did not store the word");

	// flags: set by events, cleared only by a written one
	a_flag_set: assert property (
		(err_event & `EMR_MASK_SERR) != 16'h0000 |=>
		(flag_r & $past(err_event)) == ($past(err_event) & `EMR_MASK_SERR))
		else $error("error event did not set its flag");

	a_flag_clear: assert property (
		wr && sel == EMR_SEL_FLAGS |=>
		(flag_r & $past(w1c) & ~$past(err_event)) == 16'h0000)
		else $error("written one did not clear its flag");

	// message side: every pulse must trace back to an enabled fresh rise
	a_serr_off: assert property (
		!serr_global_en |=> !hub_serr_msg)
		else $error("system-error message while globally disabled");

	a_serr_bits: assert property (
		hub_serr_msg |-> (hub_msg_src & $past(serr_en_r)) != 16'h0000)
		else $error("system-error message from no enabled source");

	a_smi_bits: assert property (
		hub_smi_msg |-> (hub_msg_src & $past(smi_en_r)) != 16'h0000)
		else $error("management message from no enabled source");

	a_sci_bits: assert property (
		hub_sci_msg |-> (hub_msg_src & $past(sci_en_r)) != 16'h0000)
		else $error("control message from no enabled source");

	a_sci_quiet: assert property (
		hub_sci_msg |-> $past(sci_en_r) != 16'h0000)
		else $error("control message with no enable set");

	a_src_only_rise: assert property (
		hub_msg_src != 16'h0000 |->
		(hub_msg_src & ~($past(flag_r) & ~$past(flag_r, 2))) == 16'h0000)
		else $error("message source without a fresh flag rise");

	a_src_with_msg: assert property (
		(hub_msg_src != 16'h0000) ==
		(hub_serr_msg || hub_smi_msg || hub_sci_msg))
		else $error("source mask and message pulses disagree");

	// a source whose enables were all off never shows up in the mask
	for (genvar b = 1; b < 10; b++) begin : g_quiet
		a_src_enabled: assert property (
			hub_msg_src[b] |->
			($past(serr_en_r[b]) && $past(serr_global_en)) ||
			$past(smi_en_r[b]) || $past(sci_en_r[b]))
			else $error("message for a source with no enable set");
	end

	c_serr_sent: cover property (
		$rose(flag_r[`EMR_BIT_LOCK_MISS]) ##1 hub_serr_msg);
	c_smi_sent: cover property (hub_smi_msg);
	c_sci_sent: cover property (hub_sci_msg);
	c_unmapped: cover property (pready && pslverr);
	c_flag_cleared: cover property (
		wr && sel == EMR_SEL_FLAGS && w1c != 16'h0000);

endmodule : emr_error_message_router

// [emr_hub_model.sv]
// Purpose: companion hub model that receives error messages
// Assumes: each message pulse lasts one pclk cycle
// Notes: keeps running counts per kind and the last source mask
module emr_hub_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic serr_msg,
	input wire logic smi_msg,
	input wire logic sci_msg,
	input wire logic [15:0] msg_src,
	output logic [7:0] n_serr,
	output logic [7:0] n_smi,
	output logic [7:0] n_sci,
	output logic [15:0] last_src
);
	timeunit 1ns;
	timeprecision 1ns;
	// counts let the bench see doubled or missing pulses, not only a level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_serr <= 8'h00;
			n_smi <= 8'h00;
			n_sci <= 8'h00;
			last_src <= 16'h0000;
		end else begin
			n_serr <= n_serr + 8'(serr_msg);
			n_smi <= n_smi + 8'(smi_msg);
			n_sci <= n_sci + 8'(sci_msg);
			if (serr_msg | smi_msg | sci_msg)
				last_src <= msg_src;
		end
	end
endmodule : emr_hub_model

// [emr_error_message_router_tb_top.sv]
// Purpose: self-checking bench of the error message router
// Assumes: apb master waits for pready, one idle cycle between transfers
// Notes: xorshift seeded at 59 draws enables, global enable and data
`include "emr_regs.svh"
module emr_error_message_router_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, hub_serr_msg, hub_smi_msg, hub_sci_msg;
	logic [15:0] err_event = 16'h0000;
	logic serr_global_en = 1'b0;
	logic [15:0] hub_msg_src, last_src;
	logic [7:0] n_serr, n_smi, n_sci;
	logic [31:0] seed = 32'h3b;
	logic [31:0] q;
	logic e;
	int n_mismatch = 0;
	int samples_checked = 0;

	always #5 pclk = ~pclk;

	emr_error_message_router #(.ADDR_W(12)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .err_event(err_event),
		.serr_global_en(serr_global_en), .hub_serr_msg(hub_serr_msg),
		.hub_smi_msg(hub_smi_msg), .hub_sci_msg(hub_sci_msg),
		.hub_msg_src(hub_msg_src));
	emr_hub_model hub (.pclk(pclk), .presetn(presetn),
		.serr_msg(hub_serr_msg), .smi_msg(hub_smi_msg),
		.sci_msg(hub_sci_msg), .msg_src(hub_msg_src), .n_serr(n_serr),
		.n_smi(n_smi), .n_sci(n_sci), .last_src(last_src));

	// ==========
	// helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function logic [15:0] wmask(input logic [7:0] i);
		case (i)
			`EMR_IDX_SERR: return `EMR_MASK_SERR;
			`EMR_IDX_SMI, `EMR_IDX_SCI: return `EMR_MASK_ECC;
			`EMR_IDX_SCRATCH: return `EMR_MASK_SCRATCH;
			default: return 16'h0000;
		endcase
	endfunction : wmask

	// one message of the chosen kind when enabled; serr also needs global
	function logic [31:0] want(input logic [1:0] kind, input logic [1:0] k,
		input logic en, input logic g);
		return 32'(k == kind && en && (kind != 2'h0 || g));
	endfunction : want

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// starts right after an edge; idle cycle after so psel is not reassigned
	task apb(input logic w, input logic [7:0] i, input logic [15:0] d);
		logic [31:0] r;
		r = rnd();
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {r[31:16], d};
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count is assumed; the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task fire(input int b, input logic [31:0] r);
		logic [15:0] m;
		logic [1:0] k;
		logic en, g, any;
		logic [7:0] s0, s1, s2;
		m = 16'h0001 << b;
		// memory sources pick a single kind: software never enables two
		k = (b == 7 || b == 8) ? 2'(r % 3) : 2'h0;
		en = r[4];
		g = r[5];
		apb(1'b1, `EMR_IDX_SERR, (k == 0 && en) ? m : 16'h0000);
		apb(1'b1, `EMR_IDX_SMI, (k == 1 && en) ? m : 16'h0000);
		apb(1'b1, `EMR_IDX_SCI, (k == 2 && en) ? m : 16'h0000);
		s0 = n_serr;
		s1 = n_smi;
		s2 = n_sci;
		serr_global_en <= g;
		err_event <= m;
		repeat (3) @(posedge pclk);
		err_event <= 16'h0000;
		repeat (4) @(posedge pclk);
		any = (k == 0 && en && g) || (k != 0 && en);
		chk(32'(8'(n_serr - s0)), want(2'h0, k, en, g));
		chk(32'(8'(n_smi - s1)), want(2'h1, k, en, g));
		chk(32'(8'(n_sci - s2)), want(2'h2, k, en, g));
		if (any)
			chk({16'h0, last_src}, {16'h0, m});
		apb(1'b1, `EMR_IDX_FLAGS, 16'h0000);
		apb(1'b0, `EMR_IDX_FLAGS, 16'h0000);
		chk(q, {16'h0, m});
		apb(1'b1, `EMR_IDX_FLAGS, m);
		apb(1'b0, `EMR_IDX_FLAGS, 16'h0000);
		chk(q, 32'h0);
	endtask : fire

	task give_verdict();
		$display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	// ==========
	// tests
	logic [7:0] idx [4] = '{`EMR_IDX_SERR, `EMR_IDX_SMI, `EMR_IDX_SCI,
		`EMR_IDX_SCRATCH};
	logic [31:0] corner [5] = '{32'h30, 32'h31, 32'h32, 32'h10, 32'h20};
	logic [31:0] d;

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (idx[k]) begin
			apb(1'b0, idx[k], 16'h0000);
			chk(q, 32'h0);
			d = rnd();
			apb(1'b1, idx[k], d[15:0]);
			apb(1'b0, idx[k], 16'h0000);
			chk(q, {16'h0, d[15:0] & wmask(idx[k])});
			chk({31'h0, e}, 32'h0);
		end
		apb(1'b1, 8'h00, 16'hffff);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 8'h01, 16'h0000);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		// low byte strobe only: the high byte must keep its old value
		apb(1'b1, `EMR_IDX_SCRATCH, 16'h1234);
		pstrb <= 4'h1;
		apb(1'b1, `EMR_IDX_SCRATCH, 16'habcd);
		pstrb <= 4'hf;
		apb(1'b0, `EMR_IDX_SCRATCH, 16'h0000);
		chk(q, 32'h0000_12cd);
		$display("test registers done");
		foreach (corner[k])
			fire((k == 2 || k == 1) ? 7 : (k == 3 ? 5 : 8), corner[k]);
		$display("test corners done");
		repeat (2) fire(9, rnd());
		repeat (2) fire(8, rnd());
		repeat (2) fire(7, rnd());
		repeat (2) fire(6, rnd());
		repeat (2) fire(5, rnd());
		repeat (2) fire(4, rnd());
		repeat (2) fire(3, rnd());
		repeat (2) fire(2, rnd());
		repeat (2) fire(1, rnd());
		$display("test random done");
		give_verdict();
	end

	initial begin
		#200000;
		n_mismatch++;
		give_verdict();
	end
endmodule : emr_error_message_router_tb_top
